// file: inc/gpio_ports_consts.vh
// Register indices, reset values and timing counts for the GPIO port block
`ifndef GPIO_PORTS_CONSTS_VH
`define GPIO_PORTS_CONSTS_VH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define IDX_PORTJ_PULL_ENABLE     6'h2c
`define IDX_PORTJ_EDGE_POLARITY   6'h2d
`define IDX_PORTJ_IRQ_ENABLE      6'h2e
`define IDX_PORTJ_IRQ_FLAGS       6'h2f
`define IDX_AD_DATA               6'h30
`define IDX_AD_PIN_LEVELS         6'h31
`define IDX_AD_DIRECTION          6'h32
`define IDX_AD_DRIVE_STRENGTH     6'h33
`define IDX_AD_PULL_ENABLE        6'h34
`define IDX_AD_PULL_SELECT        6'h35

// ********************************************************************
// Widths, positions and reset values
// ********************************************************************
`define AD_W          8
`define J_W           2
`define J_LSB         6
`define BYTE_RST      8'h00
`define J_RST         2'h0
`define WORD_ZERO     32'h0000_0000
`define FILT_CNT_W    3
`define FILT_SAMPLES  3'h4
`define FILT_ZERO     3'h0
`define FILT_ONE      3'h1

`endif

// file: hw/edge_irq_gpio_ports.v
// Two-pin edge interrupt port and eight-pin analog-shared port with APB registers
//
// Contract
// RULE1 - Polarity 0: falling edge flags, pull-up
// RULE2 - Polarity 1: rising edge flags, pull-down
// RULE3 - Per-pin enable masks port J interrupt
// RULE4 - Active edge sets flag; reads pending state
// RULE5 - Write one clears flag; zero no effect
// RULE6 - Interrupt when flag and enable both set
// RULE7 - Data read: latch if output, pin else
// RULE8 - Input register returns pins, ignores writes
// RULE9 - Direction bit: 0 input, 1 output
// RULE10 - Reads lag direction change by synchronizers
// RULE11 - Reduced drive bit, ignored for inputs
// RULE12 - Pull enable only acts on input pins
// RULE13 - All analog port pulls off after reset
// RULE14 - Converter channel enabled forces pull off
// RULE15 - Pull select: 0 up, 1 down
// RULE16 - Pins serve GPIO or peripheral functions
// RULE17 - Configuration writes accepted at any time
// RULE18 - Data register drives pin as GPIO output
// RULE19 - Edge needs four passive, four active samples
// RULE20 - Port J interrupts usable as wake request
// RULE21 - All registers reset asynchronously
// RULE22 - Single interrupt line held until flags cleared
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "gpio_ports_consts.vh"

module edge_irq_gpio_ports (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Analog-shared port pins
  input wire [`AD_W-1:0] ad_pin_in,
  output reg [`AD_W-1:0] ad_pin_out,
  output reg [`AD_W-1:0] ad_pin_oe,
  output reg [`AD_W-1:0] ad_reduced_drive,
  output reg [`AD_W-1:0] ad_pull_up,
  output reg [`AD_W-1:0] ad_pull_down,
  // Analog-shared port peripheral side
  input wire [`AD_W-1:0] analog_converter_chan_en,
  input wire [`AD_W-1:0] ad_periph_oe,
  input wire [`AD_W-1:0] ad_periph_out,
  output reg [`AD_W-1:0] ad_periph_in,
  // Port J pins
  input wire [`J_W-1:0] j_pin_in,
  output reg [`J_W-1:0] j_pin_out,
  output reg [`J_W-1:0] j_pin_oe,
  output reg [`J_W-1:0] j_pull_up,
  output reg [`J_W-1:0] j_pull_down,
  // Port J peripheral side
  input wire [`J_W-1:0] j_periph_oe,
  input wire [`J_W-1:0] j_periph_out,
  output reg [`J_W-1:0] j_periph_in,
  // Interrupt and wake request
  output reg portj_irq
);

  // ********************************************************************
  // Bus state machine and decode
  // ********************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RESP = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;

  function hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // ********************************************************************
  // Registers
  // ********************************************************************
  reg [`AD_W-1:0] ad_data_ff;
  reg [`AD_W-1:0] ad_dir_ff;
  reg [`AD_W-1:0] ad_rdr_ff;
  reg [`AD_W-1:0] ad_pe_ff;
  reg [`AD_W-1:0] ad_ps_ff;
  reg [`J_W-1:0] j_pe_ff;
  reg [`J_W-1:0] j_pol_ff;
  reg [`J_W-1:0] j_ie_ff;
  reg [`J_W-1:0] j_flag_ff;

  // Three-stage synchronisers; a change counts once stages two and three agree
  reg [`AD_W-1:0] ad_s1_ff;
  reg [`AD_W-1:0] ad_s2_ff;
  reg [`AD_W-1:0] ad_s3_ff;
  reg [`AD_W-1:0] ad_lvl_ff;
  reg [`J_W-1:0] j_s1_ff;
  reg [`J_W-1:0] j_s2_ff;
  reg [`J_W-1:0] j_s3_ff;
  reg [`J_W-1:0] j_lvl_ff;

  wire wr_now = (state_ff == ST_RESP) && psel && penable && pwrite && pstrb[0];
  wire setup = (state_ff == ST_IDLE) && psel && !penable;
  wire [7:0] wb = pwdata[7:0];
  wire [`J_W-1:0] wbj = pwdata[`J_LSB+`J_W-1:`J_LSB];
  wire [`J_W-1:0] j_event;

  // ********************************************************************
  // Read mux and address check
  // ********************************************************************
  reg [31:0] nxt_rdata;
  reg nxt_err;

  always @* begin
    nxt_rdata = `WORD_ZERO;
    nxt_err = 1'b0;
    if (hit(paddr, `IDX_AD_DATA))
      nxt_rdata[`AD_W-1:0] = (ad_dir_ff & ad_data_ff) | (~ad_dir_ff & ad_lvl_ff); // [RULE7] [RULE10]
    else if (hit(paddr, `IDX_AD_PIN_LEVELS))
      nxt_rdata[`AD_W-1:0] = ad_lvl_ff; // [RULE8]
    else if (hit(paddr, `IDX_AD_DIRECTION))
      nxt_rdata[`AD_W-1:0] = ad_dir_ff;
    else if (hit(paddr, `IDX_AD_DRIVE_STRENGTH))
      nxt_rdata[`AD_W-1:0] = ad_rdr_ff;
    else if (hit(paddr, `IDX_AD_PULL_ENABLE))
      nxt_rdata[`AD_W-1:0] = ad_pe_ff;
    else if (hit(paddr, `IDX_AD_PULL_SELECT))
      nxt_rdata[`AD_W-1:0] = ad_ps_ff;
    else if (hit(paddr, `IDX_PORTJ_PULL_ENABLE))
      nxt_rdata[`J_LSB+`J_W-1:`J_LSB] = j_pe_ff;
    else if (hit(paddr, `IDX_PORTJ_EDGE_POLARITY))
      nxt_rdata[`J_LSB+`J_W-1:`J_LSB] = j_pol_ff;
    else if (hit(paddr, `IDX_PORTJ_IRQ_ENABLE))
      nxt_rdata[`J_LSB+`J_W-1:`J_LSB] = j_ie_ff;
    else if (hit(paddr, `IDX_PORTJ_IRQ_FLAGS))
      nxt_rdata[`J_LSB+`J_W-1:`J_LSB] = j_flag_ff; // [RULE4]
    else
      nxt_err = 1'b1;
  end

  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = setup ? ST_RESP : ST_IDLE;
      ST_RESP: nxt_state = (psel && penable) ? ST_IDLE : ST_RESP;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Answer is prepared in the setup cycle, so every access takes one wait-free cycle
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin // [RULE21]
      state_ff <= ST_IDLE;
      prdata <= `WORD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (setup) begin
        prdata <= pwrite ? `WORD_ZERO : nxt_rdata;
        pready <= 1'b1;
        pslverr <= nxt_err;
      end else if (state_ff == ST_RESP && psel && penable) begin
        prdata <= `WORD_ZERO;
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Configuration registers
  // ********************************************************************
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin // [RULE21] [RULE13]
      ad_data_ff <= `BYTE_RST;
      ad_dir_ff <= `BYTE_RST;
      ad_rdr_ff <= `BYTE_RST;
      ad_pe_ff <= `BYTE_RST;
      ad_ps_ff <= `BYTE_RST;
      j_pe_ff <= `J_RST;
      j_pol_ff <= `J_RST;
      j_ie_ff <= `J_RST;
    end else if (wr_now) begin // [RULE17]
      if (hit(paddr, `IDX_AD_DATA))
        ad_data_ff <= wb; // [RULE18]
      if (hit(paddr, `IDX_AD_DIRECTION))
        ad_dir_ff <= wb; // [RULE9]
      if (hit(paddr, `IDX_AD_DRIVE_STRENGTH))
        ad_rdr_ff <= wb;
      if (hit(paddr, `IDX_AD_PULL_ENABLE))
        ad_pe_ff <= wb;
      if (hit(paddr, `IDX_AD_PULL_SELECT))
        ad_ps_ff <= wb;
      if (hit(paddr, `IDX_PORTJ_PULL_ENABLE))
        j_pe_ff <= wbj;
      if (hit(paddr, `IDX_PORTJ_EDGE_POLARITY))
        j_pol_ff <= wbj;
      if (hit(paddr, `IDX_PORTJ_IRQ_ENABLE))
        j_ie_ff <= wbj;
    end
  end

  // Set wins over a clear landing in the same cycle
  wire [`J_W-1:0] j_clr = (wr_now && hit(paddr, `IDX_PORTJ_IRQ_FLAGS)) ? wbj : `J_RST;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      j_flag_ff <= `J_RST;
      portj_irq <= 1'b0;
    end else begin
      j_flag_ff <= (j_flag_ff & ~j_clr) | j_event; // [RULE5] [RULE4]
      portj_irq <= |(((j_flag_ff & ~j_clr) | j_event) & j_ie_ff); // [RULE3] [RULE6] [RULE22] [RULE20]
    end
  end

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ad_s1_ff <= `BYTE_RST;
      ad_s2_ff <= `BYTE_RST;
      ad_s3_ff <= `BYTE_RST;
      ad_lvl_ff <= `BYTE_RST;
      j_s1_ff <= `J_RST;
      j_s2_ff <= `J_RST;
      j_s3_ff <= `J_RST;
      j_lvl_ff <= `J_RST;
    end else begin
      ad_s1_ff <= ad_pin_in;
      ad_s2_ff <= ad_s1_ff;
      ad_s3_ff <= ad_s2_ff;
      ad_lvl_ff <= (ad_s2_ff & ad_s3_ff) | (ad_lvl_ff & (ad_s2_ff ^ ad_s3_ff)); // [RULE10]
      j_s1_ff <= j_pin_in;
      j_s2_ff <= j_s1_ff;
      j_s3_ff <= j_s2_ff;
      j_lvl_ff <= (j_s2_ff & j_s3_ff) | (j_lvl_ff & (j_s2_ff ^ j_s3_ff));
    end
  end

  // ********************************************************************
  // Port J edge filters
  // ********************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `J_W; gi = gi + 1) begin : g_filt
      reg [`FILT_CNT_W-1:0] pass_cnt_ff;
      reg [`FILT_CNT_W-1:0] act_cnt_ff;
      reg fire_ff;
      // Active level follows polarity: 0 falling, 1 rising
      wire active = (j_lvl_ff[gi] == j_pol_ff[gi]); // [RULE1] [RULE2]
      wire armed = (pass_cnt_ff == `FILT_SAMPLES);
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          pass_cnt_ff <= `FILT_ZERO;
          act_cnt_ff <= `FILT_ZERO;
          fire_ff <= 1'b0;
        end else begin
          fire_ff <= 1'b0;
          if (!active) begin
            act_cnt_ff <= `FILT_ZERO;
            if (!armed)
              pass_cnt_ff <= pass_cnt_ff + `FILT_ONE;
          end else if (armed) begin
            // Fourth active sample after four passive ones accepts the edge
            if (act_cnt_ff == `FILT_SAMPLES - `FILT_ONE) begin // [RULE19]
              fire_ff <= 1'b1;
              pass_cnt_ff <= `FILT_ZERO;
              act_cnt_ff <= `FILT_ZERO;
            end else begin
              act_cnt_ff <= act_cnt_ff + `FILT_ONE;
            end
          end else begin
            pass_cnt_ff <= `FILT_ZERO;
          end
        end
      end
      assign j_event[gi] = fire_ff;
    end
  endgenerate

  // ********************************************************************
  // Pin drive, pulls and peripheral routing
  // ********************************************************************
  // A peripheral that claims a pin overrides the direction register
  wire [`AD_W-1:0] ad_oe_n = ad_periph_oe | ad_dir_ff; // [RULE16] [RULE9]
  wire [`AD_W-1:0] ad_pull = ad_pe_ff & ~ad_oe_n & ~analog_converter_chan_en; // [RULE12] [RULE14]
  wire [`J_W-1:0] j_pull = j_pe_ff & ~j_periph_oe;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ad_pin_out <= `BYTE_RST;
      ad_pin_oe <= `BYTE_RST;
      ad_reduced_drive <= `BYTE_RST;
      ad_pull_up <= `BYTE_RST;
      ad_pull_down <= `BYTE_RST;
      ad_periph_in <= `BYTE_RST;
      j_pin_out <= `J_RST;
      j_pin_oe <= `J_RST;
      j_pull_up <= `J_RST;
      j_pull_down <= `J_RST;
      j_periph_in <= `J_RST;
    end else begin
      ad_pin_out <= (ad_periph_oe & ad_periph_out) | (~ad_periph_oe & ad_data_ff); // [RULE18] [RULE16]
      ad_pin_oe <= ad_oe_n;
      ad_reduced_drive <= ad_rdr_ff & ad_oe_n; // [RULE11]
      ad_pull_up <= ad_pull & ~ad_ps_ff; // [RULE15] [RULE17]
      ad_pull_down <= ad_pull & ad_ps_ff; // [RULE15]
      ad_periph_in <= ad_lvl_ff; // [RULE16]
      j_pin_out <= j_periph_oe & j_periph_out;
      j_pin_oe <= j_periph_oe;
      j_pull_up <= j_pull & ~j_pol_ff; // [RULE1]
      j_pull_down <= j_pull & j_pol_ff; // [RULE2]
      j_periph_in <= j_lvl_ff;
    end
  end

endmodule // edge_irq_gpio_ports

// file: bench/gpio_ports_props.sv
// Port-level checker for the GPIO port block
`timescale 1ns/1ps
module gpio_ports_props (
  // Clock, reset and bus
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  // Pad controls
  input wire [7:0] ad_pin_oe,
  input wire [7:0] ad_reduced_drive,
  input wire [7:0] ad_pull_up,
  input wire [7:0] ad_pull_down,
  input wire [7:0] analog_converter_chan_en,
  input wire [1:0] j_pull_up,
  input wire [1:0] j_pull_down,
  input wire portj_irq
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_ready_follows:
    assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held");
  a_mask_irq:
    assert property (psel && penable && pready && pwrite && paddr == 8'hb8 && pstrb[0]
      && pwdata[7:6] == 2'b00 |=> ##1 !portj_irq) else $error("irq unmasked");
  a_drive_gated:
    assert property ((ad_reduced_drive & ~ad_pin_oe) == 8'h00) else $error("drive on input");
  a_pull_input:
    assert property (((ad_pull_up | ad_pull_down) & ad_pin_oe) == 8'h00) else $error("pull");
  a_pull_conv:
    assert property ($stable(analog_converter_chan_en) |->
      ((ad_pull_up | ad_pull_down) & analog_converter_chan_en) == 8'h00) else $error("conv");
  a_pull_excl:
    assert property ((ad_pull_up & ad_pull_down) == 8'h00 && (j_pull_up & j_pull_down) == 2'h0)
      else $error("both pulls");
  a_reset_clean:
    assert property ($fell(sys_rst) |-> !portj_irq && (ad_pull_up | ad_pull_down) == 8'h00)
      else $error("reset state");
  c_write: cover property (psel && penable && pready && pwrite);
  c_irq: cover property ($rose(portj_irq));
  c_pull: cover property (ad_pull_down != 8'h00);
endmodule // gpio_ports_props

bind edge_irq_gpio_ports gpio_ports_props u_props (.clock(clock), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .ad_pin_oe(ad_pin_oe), .ad_reduced_drive(ad_reduced_drive),
  .ad_pull_up(ad_pull_up), .ad_pull_down(ad_pull_down),
  .analog_converter_chan_en(analog_converter_chan_en), .j_pull_up(j_pull_up),
  .j_pull_down(j_pull_down), .portj_irq(portj_irq));

// file: bench/pin_world.sv
// Board pins: block drive, board sources, pulls, floating pads
`timescale 1ns/1ps
module pin_world (
  // Clock
  input wire clock,
  // Pad controls
  input wire [9:0] oe,
  input wire [9:0] out,
  input wire [9:0] pu,
  input wire [9:0] pd,
  // Board sources
  input wire [9:0] ext,
  input wire [9:0] ext_en,
  // Pad levels
  output wire [9:0] pad
);
  reg [9:0] float_ff = 10'h155;
  // Undriven pads with no pull toggle so a stale value never reads as valid
  always @(posedge clock) float_ff <= ~float_ff;
  assign pad = (oe & out) | (~oe & ext_en & ext)
    | (~oe & ~ext_en & (pu | (~pd & float_ff)));
endmodule // pin_world

// file: bench/edge_irq_gpio_ports_tb.sv
// Register-level testbench for the GPIO port block
`timescale 1ns/1ps
module edge_irq_gpio_ports_tb;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, re;
  logic [7:0] paddr = 0, chan_en = 0, ext_ad = 0, ext_ad_en = 0;
  logic [31:0] pwdata = 0, rv;
  logic [1:0] ext_j = 2'h1, j_poe = 0, j_pout = 0;
  logic [7:0] ad_poe = 0, ad_pout = 0;
  wire [31:0] prdata;
  wire pready, pslverr, portj_irq;
  wire [7:0] ad_pin_in, ad_pin_out, ad_pin_oe, ad_reduced_drive, ad_pull_up, ad_pull_down;
  wire [7:0] ad_periph_in;
  wire [1:0] j_pin_in, j_pin_out, j_pin_oe, j_pull_up, j_pull_down, j_periph_in;
  int errors = 0, cmp_count = 0;
  edge_irq_gpio_ports dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ad_pin_in(ad_pin_in), .ad_pin_out(ad_pin_out),
    .ad_pin_oe(ad_pin_oe), .ad_reduced_drive(ad_reduced_drive), .ad_pull_up(ad_pull_up),
    .ad_pull_down(ad_pull_down), .analog_converter_chan_en(chan_en), .ad_periph_oe(ad_poe),
    .ad_periph_out(ad_pout), .ad_periph_in(ad_periph_in), .j_pin_in(j_pin_in),
    .j_pin_out(j_pin_out), .j_pin_oe(j_pin_oe), .j_pull_up(j_pull_up),
    .j_pull_down(j_pull_down), .j_periph_oe(j_poe), .j_periph_out(j_pout),
    .j_periph_in(j_periph_in), .portj_irq(portj_irq));
  pin_world board (.clock(clock), .oe({j_pin_oe, ad_pin_oe}), .out({j_pin_out, ad_pin_out}),
    .pu({j_pull_up, ad_pull_up}), .pd({j_pull_down, ad_pull_down}), .ext({ext_j, ext_ad}),
    .ext_en({2'h3, ext_ad_en}), .pad({j_pin_in, ad_pin_in}));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task final_report;
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask
  // One APB transfer; an idle cycle follows so strobes never toggle twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      final_report();
    end
    rv = prdata; re = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", rv, {24'h0, e});
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  logic [7:0] cfg [8] = '{8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hc8, 8'hcc, 8'hd0, 8'hd4};
  initial begin
    tick(5);
    sys_rst <= 0;
    tick(1);
    for (int i = 0; i < 8; i++) rd(cfg[i], 8'h00);
    wr(8'hc0, 8'ha5);
    wr(8'hc8, 8'h0f);
    ext_ad <= 8'h30; ext_ad_en <= 8'hf0;
    tick(6);
    chk("pin_oe", ad_pin_oe, 8'h0f);
    chk("pin_out", ad_pin_out & 8'h0f, 8'h05);
    rd(8'hc0, 8'h35);
    wr(8'hc4, 8'hff);
    rd(8'hc4, 8'h35);
    chk("periph_in", ad_periph_in, 8'h35);
    wr(8'hc8, 8'hff);
    tick(6);
    rd(8'hc0, 8'ha5);
    rd(8'hc4, 8'ha5);
    wr(8'hc8, 8'h0f);
    wr(8'hcc, 8'hff);
    wr(8'hd0, 8'hff);
    wr(8'hd4, 8'hf0);
    chan_en <= 8'h40;
    tick(2);
    chk("drive", ad_reduced_drive, 8'h0f);
    chk("pull_down", ad_pull_down, 8'hb0);
    chk("pull_up", ad_pull_up, 8'h00);
    wr(8'hd4, 8'h00);
    tick(2);
    chk("pull_up", ad_pull_up, 8'hb0);
    wr(8'hb8, 8'hc0);
    wr(8'hb4, 8'h80);
    // Upper pin sits low before its polarity turns rising, so no stray edge
    ext_j <= 2'b00;
    tick(12);
    rd(8'hbc, 8'h40);
    chk("irq", portj_irq, 1'b1);
    ext_j <= 2'b01;
    tick(12);
    rd(8'hbc, 8'h40);
    ext_j <= 2'b10;
    tick(12);
    rd(8'hbc, 8'hc0);
    wr(8'hbc, 8'h00);
    rd(8'hbc, 8'hc0);
    wr(8'hbc, 8'h40);
    rd(8'hbc, 8'h80);
    chk("irq", portj_irq, 1'b1);
    wr(8'hb8, 8'h00);
    // Request is registered one edge after the new mask lands
    tick(1);
    chk("irq", portj_irq, 1'b0);
    wr(8'hbc, 8'h80);
    rd(8'hbc, 8'h00);
    ext_j <= 2'b11;
    tick(12);
    ext_j <= 2'b10;
    tick(3);
    ext_j <= 2'b01;
    tick(12);
    rd(8'hbc, 8'h00);
    wr(8'hb0, 8'hc0);
    tick(1);
    chk("j_pulls", {j_pull_up, j_pull_down}, 4'h6);
    j_poe <= 2'b01; j_pout <= 2'b01;
    ad_poe <= 8'hc0;
    ad_pout <= 8'h40;
    tick(2);
    chk("j_drive", {j_pin_oe, j_pin_out & 2'b01}, 4'h5);
    chk("j_pull_up", j_pull_up, 2'b00);
    chk("ad_periph_drive", {ad_pin_oe, ad_pin_out}, {8'hcf, 8'h65});
    chk("j_periph_in", j_periph_in, 2'b01);
    apb(1'b0, 8'h00, 32'h0);
    chk("slverr", re, 1'b1);
    chk("slverr_data", rv, 32'h0);
    final_report();
  end
endmodule // edge_irq_gpio_ports_tb
